// *** rtl/nfl_pkg.sv ***
// Purpose: shared constants and types of the flash control block
// Assumes: 32-bit AHB-Lite register bus, byte addresses as printed
// Notes:   block-range, configuration and status fields live here too
package nfl_pkg;

  localparam logic [31:0] NFL_CONTROL_ADDR = 32'h4E000004;
  localparam logic [31:0] NFL_COMMAND_ADDR = 32'h4E000008;
  // offsets chosen for settings the control word leaves out
  localparam logic [31:0] NFL_CONFIG_ADDR  = 32'h4E000000;
  localparam logic [31:0] NFL_STATUS_ADDR  = 32'h4E000020;
  localparam logic [31:0] NFL_FIRST_ADDR   = 32'h4E000038;
  localparam logic [31:0] NFL_END_ADDR     = 32'h4E00003C;
  localparam logic [31:0] NFL_REQ_ADDR     = 32'h4E000040;
  localparam logic [31:0] NFL_MPAR_ADDR    = 32'h4E00002C;
  localparam logic [31:0] NFL_SPAR_ADDR    = 32'h4E000034;
  localparam logic [31:0] NFL_DATA_ADDR    = 32'h4E000010;

  localparam logic [15:0] NFL_CONTROL_RST  = 16'h0384;
  localparam logic [15:0] NFL_CONTROL_WMSK = 16'h3762;
  localparam logic [7:0]  NFL_COMMAND_RST  = 8'h00;
  localparam logic [1:0]  NFL_SETUP_RST    = 2'h1;
  localparam logic [2:0]  NFL_STROBE_RST   = 3'h0;

  localparam int NFL_EN_BIT      = 0;
  localparam int NFL_CS_BIT      = 1;
  localparam int NFL_PCLR_BIT    = 4;
  localparam int NFL_MFRZ_BIT    = 5;
  localparam int NFL_SFRZ_BIT    = 6;
  localparam int NFL_EDGE_BIT    = 8;
  localparam int NFL_RBIE_BIT    = 9;
  localparam int NFL_ILIE_BIT    = 10;
  localparam int NFL_SOFT_BIT    = 12;
  localparam int NFL_TIGHT_BIT   = 13;
  localparam int NFL_STAT_RB_BIT = 0;
  localparam int NFL_STAT_EV_BIT = 2;
  localparam int NFL_STAT_IL_BIT = 3;
  localparam int NFL_SETUP_LSB   = 12;
  localparam int NFL_STROBE_LSB  = 8;

  localparam int NFL_BLK_W = 17;

  typedef enum logic [1:0] {NFL_REQ_READ, NFL_REQ_PROG, NFL_REQ_ERASE}
    nfl_req_kind_t;

  typedef struct packed {
    logic [7:0] io;
    logic       cle;
    logic       we_n;
    logic       io_oe_n;
  } nfl_pins_t;

endpackage

// *** rtl/nfl_ctrl.sv ***
// Purpose: control and command registers of a NAND flash controller
// Assumes: single AHB-Lite master, word transfers, one clock
// Notes:   parity engine is a simple xor accumulator per area
// What this block does
// - lock-tight bit set-only by software
// - lock-tight cleared only by reset or wake
// - locked blocks reject program and erase
// - locked program or erase sets illegal flag
// - equal first and end blocks locks all
// - soft lock resets to zero, freely writable
// - illegal access interrupt gated by enable
// - ready/busy interrupt gated by enable
// - edge select: zero rising, one falling
// - spare parity frozen while its lock set
// - main parity frozen while its lock set
// - parity clear bit write-only, reads zero
// - chip select force drives active-low select
// - chip select force works only when enabled
// - boot loading drives chip select itself
// - controller disabled performs no flash operations
// - command register holds eight bits, resets zero
// - control register resets to printed value
// - latch setup lasts setup count clocks
// - strobe lasts strobe count plus one clocks
// - unlocked parity updates on each data word while enabled
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module nfl_ctrl
  import nfl_pkg::*;
#(
  parameter int BLK_W = NFL_BLK_W
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        wake,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // boot loader
  input  wire logic        boot_active,
  input  wire logic        boot_cs_n,
  // flash pins
  input  wire logic        flash_ready_busy,
  input  wire logic [7:0]  flash_io_in,
  output nfl_pins_t        flash_pins,
  output logic             flash_chip_select_n,
  // interrupt lines
  output logic             illegal_irq,
  output logic             ready_busy_irq
);
  import nfl_pkg::*;

  typedef enum {ST_IDLE, ST_SETUP, ST_STROBE} nfl_state_t;

  logic [15:0]      control_q;
  logic [7:0]       command_q;
  logic [1:0]       setup_q;
  logic [2:0]       strobe_q;
  logic [BLK_W-1:0] first_q;
  logic [BLK_W-1:0] end_q;
  logic             illegal_q;
  logic             rb_event_q;
  logic [7:0]       mpar_q;
  logic [7:0]       spar_q;
  logic             rb_s1_q;
  logic             rb_s2_q;
  logic             rb_s3_q;
  logic             ap_write_q;
  logic             ap_read_q;
  logic [31:0]      ap_addr_q;
  nfl_state_t       state_q;
  logic [2:0]       count_q;
  nfl_pins_t        pins_q;
  logic             wr_ctrl;
  logic             wr_cmd;
  logic             wr_req;
  logic             lock_on;
  logic             blk_locked;
  logic             rb_edge;
  logic             data_word;
  logic [7:0]       data_byte;
  logic             clr;

  function automatic logic wr_to(input logic [31:0] a);
    return ap_write_q && (ap_addr_q == a);
  endfunction

  assign clr     = reset | wake;
  assign wr_ctrl = wr_to(NFL_CONTROL_ADDR);
  assign wr_cmd  = wr_to(NFL_COMMAND_ADDR);
  assign wr_req  = wr_to(NFL_REQ_ADDR);

  // address phase capture; slave never inserts wait states
  always_ff @(posedge clk) begin
    if (reset) begin
      ap_write_q <= 1'b0;
      ap_read_q  <= 1'b0;
      ap_addr_q  <= 32'h00000000;
    end else if (hready) begin
      ap_write_q <= hsel & htrans[1] & hwrite;
      ap_read_q  <= hsel & htrans[1] & ~hwrite;
      ap_addr_q  <= haddr;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // control register
  always_ff @(posedge clk) begin
    if (clr) begin
      control_q <= NFL_CONTROL_RST;
    end else if (wr_ctrl) begin
      control_q <= hwdata[15:0] & NFL_CONTROL_WMSK;
      control_q[NFL_TIGHT_BIT] <= control_q[NFL_TIGHT_BIT] |
                                  hwdata[NFL_TIGHT_BIT];
      control_q[NFL_EN_BIT] <= hwdata[NFL_EN_BIT];
      control_q[NFL_PCLR_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      command_q <= NFL_COMMAND_RST;
    end else if (wr_cmd) begin
      command_q <= hwdata[7:0];
    end
  end

  // configuration and block range registers
  always_ff @(posedge clk) begin
    if (reset) begin
      setup_q  <= NFL_SETUP_RST;
      strobe_q <= NFL_STROBE_RST;
      first_q  <= '0;
      end_q    <= '0;
    end else begin
      if (wr_to(NFL_CONFIG_ADDR)) begin
        setup_q  <= hwdata[NFL_SETUP_LSB +: 2];
        strobe_q <= hwdata[NFL_STROBE_LSB +: 3];
      end
      if (wr_to(NFL_FIRST_ADDR)) first_q <= hwdata[BLK_W-1:0];
      if (wr_to(NFL_END_ADDR))   end_q   <= hwdata[BLK_W-1:0];
    end
  end

  // program/erase requests are checked against the unlocked window
  assign lock_on = control_q[NFL_SOFT_BIT] | control_q[NFL_TIGHT_BIT];
  assign blk_locked = lock_on &&
    ((first_q == end_q) ||
     (hwdata[BLK_W-1:0] < first_q) || (hwdata[BLK_W-1:0] >= end_q));

  always_ff @(posedge clk) begin
    if (reset) begin
      illegal_q <= 1'b0;
    end else if (wr_req && hwdata[31:30] != 2'(NFL_REQ_READ) &&
                 blk_locked) begin
      illegal_q <= 1'b1;
    end else if (wr_to(NFL_STATUS_ADDR) && hwdata[NFL_STAT_IL_BIT]) begin
      illegal_q <= 1'b0;
    end
  end

  // ready/busy synchroniser and edge detect
  always_ff @(posedge clk) begin
    if (reset) begin
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
      rb_s3_q <= 1'b1;
    end else begin
      rb_s1_q <= flash_ready_busy;
      rb_s2_q <= rb_s1_q;
      rb_s3_q <= rb_s2_q;
    end
  end

  assign rb_edge = control_q[NFL_EDGE_BIT] ? (rb_s3_q & ~rb_s2_q)
                                           : (~rb_s3_q & rb_s2_q);

  // set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (reset) begin
      rb_event_q <= 1'b0;
    end else if (rb_edge) begin
      rb_event_q <= 1'b1;
    end else if (wr_to(NFL_STATUS_ADDR) && hwdata[NFL_STAT_EV_BIT]) begin
      rb_event_q <= 1'b0;
    end
  end

  assign illegal_irq    = illegal_q & control_q[NFL_ILIE_BIT];
  assign ready_busy_irq = rb_event_q & control_q[NFL_RBIE_BIT];

  // parity accumulators fed by data register words
  assign data_word = control_q[NFL_EN_BIT] &&
                     (ap_read_q || ap_write_q) &&
                     ap_addr_q == NFL_DATA_ADDR;
  // reads fold in the byte on the pins, writes the byte going out
  assign data_byte = ap_write_q ? hwdata[7:0] : flash_io_in;

  always_ff @(posedge clk) begin
    if (reset || (wr_ctrl && hwdata[NFL_PCLR_BIT])) begin
      mpar_q <= 8'h00;
      spar_q <= 8'h00;
    end else if (data_word) begin
      if (!control_q[NFL_MFRZ_BIT])
        mpar_q <= mpar_q ^ data_byte;
      if (!control_q[NFL_SFRZ_BIT])
        spar_q <= spar_q ^ data_byte;
    end
  end

  // command cycle sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      count_q <= 3'h0;
      pins_q  <= '{io: 8'h00, cle: 1'b0, we_n: 1'b1, io_oe_n: 1'b1};
    end else begin
      case (state_q)
        ST_IDLE: begin
          pins_q.we_n <= 1'b1;
          pins_q.cle  <= 1'b0;
          if (wr_cmd && control_q[NFL_EN_BIT]) begin
            pins_q.io      <= hwdata[7:0];
            pins_q.cle     <= 1'b1;
            pins_q.io_oe_n <= 1'b0;
            count_q        <= {1'b0, setup_q};
            state_q <= (setup_q == 2'h0) ? ST_STROBE : ST_SETUP;
            if (setup_q == 2'h0) begin
              pins_q.we_n <= 1'b0;
              count_q     <= strobe_q;
            end
          end else begin
            pins_q.io_oe_n <= 1'b1;
          end
        end
        ST_SETUP: begin
          if (count_q == 3'h1) begin
            pins_q.we_n <= 1'b0;
            count_q     <= strobe_q;
            state_q     <= ST_STROBE;
          end else begin
            count_q <= count_q - 3'h1;
          end
        end
        ST_STROBE: begin
          if (count_q == 3'h0) begin
            pins_q.we_n <= 1'b1;
            state_q     <= ST_IDLE;
          end else begin
            count_q <= count_q - 3'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign flash_pins = pins_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      flash_chip_select_n <= 1'b1;
    end else if (boot_active) begin
      flash_chip_select_n <= boot_cs_n;
    end else if (control_q[NFL_EN_BIT]) begin
      flash_chip_select_n <= control_q[NFL_CS_BIT];
    end else begin
      flash_chip_select_n <= 1'b1;
    end
  end

  // read data; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr)
        NFL_CONTROL_ADDR: hrdata <= {16'h0000, control_q};
        NFL_COMMAND_ADDR: hrdata <= {24'h000000, command_q};
        NFL_CONFIG_ADDR:  hrdata <= {18'h0, setup_q, 1'b0, strobe_q, 8'h00};
        NFL_STATUS_ADDR:  hrdata <= {28'h0, illegal_q, rb_event_q,
                                     1'b0, rb_s2_q};
        NFL_FIRST_ADDR:   hrdata <= 32'(first_q);
        NFL_END_ADDR:     hrdata <= 32'(end_q);
        NFL_MPAR_ADDR:    hrdata <= {24'h000000, mpar_q};
        NFL_SPAR_ADDR:    hrdata <= {24'h000000, spar_q};
        default:          hrdata <= 32'h00000000;
      endcase
    end
  end

endmodule // nfl_ctrl

// *** verif/nfl_flash_model.sv ***
// Purpose: behavioural flash device on the far side of the control block
// Assumes: a command is latched on the write strobe's rising edge
// Notes:   busy for BUSY clocks after each command it accepts
`timescale 1ns/100ps
module nfl_flash_model
  import nfl_pkg::*;
#(
  parameter int BUSY = 6
) (
  // clock
  input  wire logic               clk,
  // flash pins
  input  wire nfl_pkg::nfl_pins_t pins,
  input  wire logic               cs_n,
  output logic                    rb,
  output logic [7:0]              io_in
);
  logic [7:0] cmd_q = 8'h00;
  logic [7:0] pat_q = 8'h5A;
  logic       we_q  = 1'b1;
  int         cnt_q = 0;
  int         busy_q = 0;
  // deselected bus toggles so a stale value is never mistaken for data
  assign io_in = cs_n ? pat_q : 8'hC3;
  assign rb    = (busy_q == 0);
  always @(posedge clk) begin
    pat_q <= ~pat_q;
    we_q  <= pins.we_n;
    if (busy_q != 0)
      busy_q <= busy_q - 1;
    // cnt_q counts latch strobes on the wire, selected or not
    if (pins.we_n && !we_q && pins.cle) begin
      cnt_q <= cnt_q + 1;
      if (!cs_n) begin
        cmd_q  <= pins.io;
        busy_q <= BUSY;
      end
    end
  end
endmodule // nfl_flash_model

// *** verif/nfl_ctrl_checker.sv ***
// Purpose: port-level checks of the flash control block
// Assumes: setup count 1 and strobe count 0 stay at reset values
// Notes:   bound into every nfl_ctrl instance
`timescale 1ns/100ps
module nfl_ctrl_checker
  import nfl_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               wake,
  // bus
  input wire logic               hsel,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // flash side
  input wire logic               boot_active,
  input wire logic               boot_cs_n,
  input wire nfl_pkg::nfl_pins_t flash_pins,
  input wire logic               flash_chip_select_n,
  input wire logic               illegal_irq,
  input wire logic               ready_busy_irq
);
  logic wdp_q;
  // high during the data phase of a taken write
  always_ff @(posedge clk) begin
    if (reset)
      wdp_q <= 1'b0;
    else
      wdp_q <= hsel && hready && htrans[1] && hwrite;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  reset_idle_a: assert property (
    $fell(reset) |-> flash_chip_select_n && flash_pins.we_n &&
    !flash_pins.cle && flash_pins.io_oe_n && !illegal_irq)
    else $error("pins not idle after reset");
  setup_len_a: assert property (
    $rose(flash_pins.cle) |-> flash_pins.we_n ##1 !flash_pins.we_n)
    else $error("latch setup length wrong");
  strobe_len_a: assert property (
    $fell(flash_pins.we_n) |-> ##1 flash_pins.we_n)
    else $error("strobe length wrong");
  cmd_drive_a: assert property (
    flash_pins.cle |-> !flash_pins.io_oe_n)
    else $error("latch asserted without driving");
  cmd_release_a: assert property (
    $rose(flash_pins.we_n) && flash_pins.cle |->
    ##1 !flash_pins.cle && flash_pins.io_oe_n)
    else $error("latch not released after strobe");
  io_hold_a: assert property (
    flash_pins.cle && $past(flash_pins.cle) |-> $stable(flash_pins.io))
    else $error("command byte moved under latch");
  boot_cs_a: assert property (
    boot_active && $past(boot_active) |->
    flash_chip_select_n == $past(boot_cs_n))
    else $error("select not following boot loader");
  cs_cause_a: assert property (
    $changed(flash_chip_select_n) && !boot_active && !$past(boot_active) &&
    !$past(boot_active, 2)
    |-> $past(wdp_q) || $past(wdp_q, 2) || $past(wake) || $past(wake, 2))
    else $error("select moved without a write");
  irq_cause_a: assert property (
    $rose(illegal_irq) |-> $past(wdp_q))
    else $error("illegal interrupt without a write");
  cover property ($fell(flash_pins.we_n) && flash_pins.cle);
  cover property ($rose(illegal_irq));
  cover property ($rose(ready_busy_irq));
endmodule // nfl_ctrl_checker

bind nfl_ctrl nfl_ctrl_checker nfl_ctrl_checker_i (.*);

// *** verif/nfl_ctrl_tb_top.sv ***
// Purpose: directed register tests of the flash control block
// Assumes: setup and strobe counts left at their reset values
// Notes:   one idle cycle separates bus transfers
`timescale 1ns/100ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  failures++; $display("ERROR %s exp %h got %h", n, e, s); end end
module nfl_ctrl_tb_top;
  import nfl_pkg::*;
  logic        clk, reset, wake, hsel, hwrite, hreadyout, hresp;
  logic        boot_active, boot_cs_n, rb, cs_n, ill_irq, rb_irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [7:0]  io_in;
  nfl_pins_t   pins;
  int          failures, num_checks;
  nfl_ctrl #(.BLK_W(NFL_BLK_W)) nfl_ctrl_i (.clk(clk), .reset(reset),
    .wake(wake), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .boot_active(boot_active), .boot_cs_n(boot_cs_n),
    .flash_ready_busy(rb), .flash_io_in(io_in), .flash_pins(pins),
    .flash_chip_select_n(cs_n), .illegal_irq(ill_irq),
    .ready_busy_irq(rb_irq));
  nfl_flash_model nfl_flash_model_i (.clk(clk), .pins(pins), .cs_n(cs_n),
    .rb(rb), .io_in(io_in));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // clears status first so each request is judged alone
  task automatic req(input logic [1:0] k, input logic [16:0] b,
                     input logic e);
    wr(NFL_STATUS_ADDR, 32'h0000000C);
    wr(NFL_REQ_ADDR, {k, 13'h0000, b});
    rd(NFL_STATUS_ADDR);
    `CHK("illegal", e, rdv[NFL_STAT_IL_BIT])
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test;
  end
  initial begin
    {reset, wake, hsel, htrans, hwrite, haddr, hwdata} = '0;
    {boot_active, boot_cs_n, hsize} = {1'b0, 1'b1, 3'h2};
    {failures, num_checks} = '0;
    reset = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(NFL_CONTROL_ADDR);
    `CHK("ctl", NFL_CONTROL_RST, rdv[15:0])
    rd(NFL_COMMAND_ADDR);
    `CHK("cmd", 32'h0, rdv)
    wr(NFL_CONTROL_ADDR, 32'h0);
    cmd_wr: wr(NFL_COMMAND_ADDR, 32'h60);
    tick(30);
    `CHK("cs_n", 1'b1, cs_n)
    `CHK("strobes", 0, nfl_flash_model_i.cnt_q)
    wr(NFL_CONTROL_ADDR, 32'h1);
    tick(3);
    `CHK("cs_n", 1'b0, cs_n)
    boot_active <= 1'b1;
    tick(3);
    `CHK("cs_n", 1'b1, cs_n)
    boot_active <= 1'b0;
    $display("test select done");
    wr(NFL_STATUS_ADDR, 32'h0000000C);
    wr(NFL_COMMAND_ADDR, 32'h0000FF70);
    rd(NFL_COMMAND_ADDR);
    `CHK("cmd", 32'h70, rdv)
    tick(2);
    rd(NFL_STATUS_ADDR);
    `CHK("rb_event", 1'b0, rdv[NFL_STAT_EV_BIT])
    `CHK("rb_sync", 1'b0, rdv[NFL_STAT_RB_BIT])
    tick(30);
    `CHK("flash_cmd", 8'h70, nfl_flash_model_i.cmd_q)
    rd(NFL_STATUS_ADDR);
    `CHK("rb_event", 1'b1, rdv[NFL_STAT_EV_BIT])
    `CHK("rb_irq", 1'b0, rb_irq)
    wr(NFL_CONTROL_ADDR, 32'h0301);
    wr(NFL_STATUS_ADDR, 32'h0000000C);
    wr(NFL_COMMAND_ADDR, 32'hD0);
    tick(7);
    `CHK("rb_irq", 1'b1, rb_irq)
    $display("test command done");
    wr(NFL_CONTROL_ADDR, 32'h0011);
    rd(NFL_CONTROL_ADDR);
    `CHK("clr_bit", 1'b0, rdv[NFL_PCLR_BIT])
    wr(NFL_DATA_ADDR, 32'h0000003C);
    rd(NFL_MPAR_ADDR);
    `CHK("mpar", 8'h3C, rdv[7:0])
    wr(NFL_CONTROL_ADDR, 32'h0061);
    wr(NFL_DATA_ADDR, 32'h000000FF);
    rd(NFL_MPAR_ADDR);
    `CHK("mpar", 8'h3C, rdv[7:0])
    rd(NFL_SPAR_ADDR);
    `CHK("spar", 8'h3C, rdv[7:0])
    wr(NFL_CONTROL_ADDR, 32'h0021);
    rd(NFL_DATA_ADDR);
    rd(NFL_SPAR_ADDR);
    `CHK("spar", 8'hFF, rdv[7:0])
    rd(NFL_MPAR_ADDR);
    `CHK("mpar", 8'h3C, rdv[7:0])
    wr(NFL_CONTROL_ADDR, 32'h0041);
    wr(NFL_DATA_ADDR, 32'h0000000F);
    rd(NFL_MPAR_ADDR);
    `CHK("mpar", 8'h33, rdv[7:0])
    rd(NFL_SPAR_ADDR);
    `CHK("spar", 8'hFF, rdv[7:0])
    wr(NFL_CONTROL_ADDR, 32'h0011);
    rd(NFL_MPAR_ADDR);
    `CHK("mpar", 8'h00, rdv[7:0])
    $display("test parity done");
    wr(NFL_FIRST_ADDR, 32'h4);
    wr(NFL_END_ADDR, 32'h8);
    wr(NFL_CONTROL_ADDR, 32'h1001);
    req(NFL_REQ_PROG, 17'h5, 1'b0);
    req(NFL_REQ_ERASE, 17'h8, 1'b1);
    `CHK("ill_irq", 1'b0, ill_irq)
    wr(NFL_CONTROL_ADDR, 32'h1401);
    req(NFL_REQ_PROG, 17'h3, 1'b1);
    `CHK("ill_irq", 1'b1, ill_irq)
    req(NFL_REQ_READ, 17'h3, 1'b0);
    wr(NFL_END_ADDR, 32'h4);
    req(NFL_REQ_PROG, 17'h4, 1'b1);
    wr(NFL_CONTROL_ADDR, 32'h0001);
    req(NFL_REQ_PROG, 17'h4, 1'b0);
    wr(NFL_CONTROL_ADDR, 32'h2001);
    wr(NFL_CONTROL_ADDR, 32'h0001);
    rd(NFL_CONTROL_ADDR);
    `CHK("tight", 1'b1, rdv[NFL_TIGHT_BIT])
    req(NFL_REQ_ERASE, 17'h4, 1'b1);
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    rd(NFL_CONTROL_ADDR);
    `CHK("ctl", NFL_CONTROL_RST, rdv[15:0])
    $display("test lock done");
    finish_test;
  end
endmodule // nfl_ctrl_tb_top
